// *** rtl/sps_cfg.svh ***
`ifndef SPS_CFG_SVH
`define SPS_CFG_SVH

// ****************************************
// Register map
// ****************************************
`define SPS_ADDR_CTRL 8'h00
`define SPS_ADDR_STATUS 8'h04
`define SPS_ADDR_STEPCNT 8'h08
`define SPS_CTRL_RESET 32'h0000_0001
`define SPS_CTRL_SWEN_BIT 0
`define SPS_STAT_MISS_BIT 11

// ****************************************
// Synchronised level inputs
// ****************************************
`define SPS_NUM_IN 8
`define SPS_IN_EDGE 0
`define SPS_IN_EXC 1
`define SPS_IN_DIR 2
`define SPS_IN_EN 3
`define SPS_IN_SYSRST 4
`define SPS_IN_OC 5
`define SPS_IN_OT 6
`define SPS_IN_ALM 7

// ****************************************
// Sequencer
// ****************************************
`define SPS_PHASE_INIT 3'h0
`define SPS_CNT_W 16

`endif

// *** rtl/sps_pkg.sv ***
package sps_pkg;

  typedef logic [2:0] sps_phase_t;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    sps_phase_t phase;
    logic fault;
    logic sw_en;
    logic miss;
    logic [15:0] step_count;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [3:0] win;
    logic alarm_oe;
    logic [31:0] rdata;
    logic ready;
    logic resp;
  } sps_core_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic rise_tgl;
    logic fall_tgl;
  } sps_link_t;

  typedef struct packed {
    logic [1:0] r_s1;
    logic [1:0] r_s2;
    logic [1:0] r_s3;
  } sps_rx_t;

endpackage : sps_pkg

// *** rtl/sps_step_if.sv ***
interface sps_step_if;
  logic rise_tgl;
  logic fall_tgl;
  logic rise_evt;
  logic fall_evt;

  modport link (output rise_tgl, output fall_tgl);
  modport rx (input rise_tgl, input fall_tgl, output rise_evt, output fall_evt);
  modport core (input rise_evt, input fall_evt);
endinterface : sps_step_if

// *** rtl/sps_step_link.sv ***
module sps_step_link (
  // Link clock and reset
  input wire logic link_clk,
  input wire logic hresetn,
  // Step clock pin
  input wire logic step_clock,
  // Edge toggles
  sps_step_if.link lnk
);
  sps_pkg::sps_link_t r;
  sps_pkg::sps_link_t n;

  always_comb begin
    n = r;
    n.s1 = step_clock;
    n.s2 = r.s1;
    n.s3 = r.s2;
    // One toggle per edge, so no edge is lost across the crossing
    if (r.s2 && !r.s3) begin
      n.rise_tgl = !r.rise_tgl;
    end
    if (!r.s2 && r.s3) begin
      n.fall_tgl = !r.fall_tgl;
    end
  end

  always_ff @(posedge link_clk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign lnk.rise_tgl = r.rise_tgl;
  assign lnk.fall_tgl = r.fall_tgl;
endmodule : sps_step_link

// *** rtl/sps_step_rx.sv ***
module sps_step_rx (
  // System clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Toggles in, pulses out
  sps_step_if.rx stp
);
  sps_pkg::sps_rx_t r;
  sps_pkg::sps_rx_t n;

  always_comb begin
    n = r;
    n.r_s1 = {stp.fall_tgl, stp.rise_tgl};
    n.r_s2 = r.r_s1;
    n.r_s3 = r.r_s2;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign stp.rise_evt = r.r_s2[0] ^ r.r_s3[0];
  assign stp.fall_evt = r.r_s2[1] ^ r.r_s3[1];
endmodule : sps_step_rx

// *** rtl/sps_sequencer.sv ***
`include "sps_cfg.svh"

module sps_sequencer (
  // System clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link clock
  input wire logic link_clk,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Controller pins
  input wire logic step_clock,
  input wire logic edge_select,
  input wire logic excitation_select,
  input wire logic direction_select,
  input wire logic enable,
  input wire logic system_reset_low,
  // Detector inputs
  input wire logic overcurrent_detect,
  input wire logic overheat_detect,
  // Winding outputs
  output logic winding1_pos,
  output logic winding1_neg,
  output logic winding2_pos,
  output logic winding2_neg,
  // Open-drain alarm, active low
  input wire logic alarm_low_i,
  output logic alarm_low_o,
  output logic alarm_low_oe
);

  // ****************************************
  // Step clock crossing
  // ****************************************
  sps_step_if stp ();

  sps_step_link u_link (
    .link_clk(link_clk),
    .hresetn(hresetn),
    .step_clock(step_clock),
    .lnk(stp.link)
  );

  sps_step_rx u_rx (
    .hclk(hclk),
    .hresetn(hresetn),
    .stp(stp.rx)
  );

  // ****************************************
  // State
  // ****************************************
  sps_pkg::sps_core_t r;
  sps_pkg::sps_core_t n;

  logic [`SPS_NUM_IN-1:0] pins;
  logic edge_sel;
  logic exc_half;
  logic dir_rev;
  logic en_pin;
  logic sys_run;
  logic detect;
  logic step;
  logic run;
  logic addr_ok;
  logic [31:0] status;

  // The alarm wire read-back passes the same synchroniser as the pins
  assign pins = {alarm_low_i, overheat_detect, overcurrent_detect, system_reset_low, enable, direction_select,
                 excitation_select, edge_select};

  assign edge_sel = r.s2[`SPS_IN_EDGE];
  assign exc_half = r.s2[`SPS_IN_EXC];
  assign dir_rev = r.s2[`SPS_IN_DIR];
  assign en_pin = r.s2[`SPS_IN_EN];
  assign sys_run = r.s2[`SPS_IN_SYSRST];
  assign detect = r.s2[`SPS_IN_OC] | r.s2[`SPS_IN_OT];

  // Position 0 is winding1_pos with winding2_neg; even positions drive two windings
  function automatic logic [3:0] sps_decode(input sps_pkg::sps_phase_t p);
    logic w1p;
    logic w1n;
    logic w2p;
    logic w2n;
    w1p = (p == 3'h0) || (p == 3'h1) || (p == 3'h2);
    w2p = (p == 3'h2) || (p == 3'h3) || (p == 3'h4);
    w1n = (p == 3'h4) || (p == 3'h5) || (p == 3'h6);
    w2n = (p == 3'h6) || (p == 3'h7) || (p == 3'h0);
    return {w1p, w1n, w2p, w2n};
  endfunction : sps_decode

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n = r;
    n.s1 = pins;
    n.s2 = r.s1;
    step = stp.rise_evt || (stp.fall_evt && !edge_sel);
    run = sys_run && en_pin && r.sw_en && !r.fault;
    addr_ok = hsel && hready && htrans[1];
    status = {20'h0, r.s2[`SPS_IN_ALM], r.miss, r.fault, r.s2[`SPS_IN_OT], r.s2[`SPS_IN_OC], en_pin,
              dir_rev, exc_half, edge_sel, r.phase};

    if (!sys_run) begin
      n.phase = `SPS_PHASE_INIT;
      n.fault = 1'b0;
    end else begin
      if (detect) begin
        n.fault = 1'b1;
      end
      if (step && run) begin
        if (exc_half) begin
          n.phase = dir_rev ? r.phase - 3'h1 : r.phase + 3'h1;
        end else if (r.phase[0]) begin
          n.phase = dir_rev ? r.phase - 3'h1 : r.phase + 3'h1;
        end else begin
          n.phase = dir_rev ? r.phase - 3'h2 : r.phase + 3'h2;
        end
        n.step_count = r.step_count + 16'h0001;
      end
    end

    // Output gating; the phase stays where it is while gated by enable, control bit or a fault latched in an earlier cycle
    if (run && !n.fault) begin
      n.win = sps_decode(n.phase);
    end else begin
      n.win = 4'h0;
    end
    n.alarm_oe = n.fault || detect;

    // Bus write in data phase
    n.wr_pend = addr_ok && hwrite;
    n.wr_addr = haddr[7:0];
    if (r.wr_pend) begin
      case (r.wr_addr)
        `SPS_ADDR_CTRL: begin
          n.sw_en = hwdata[`SPS_CTRL_SWEN_BIT];
        end
        `SPS_ADDR_STATUS: begin
          if (hwdata[`SPS_STAT_MISS_BIT]) begin
            n.miss = 1'b0;
          end
        end
        `SPS_ADDR_STEPCNT: begin
          n.step_count = 16'h0000;
        end
        default: begin
        end
      endcase
    end
    // A step lost while gated sets the flag over a clear
    if (step && !run) begin
      n.miss = 1'b1;
    end

    // Bus read data for the following data phase
    n.rdata = 32'h0;
    if (addr_ok && !hwrite) begin
      case (haddr[7:0])
        `SPS_ADDR_CTRL: begin
          n.rdata = {31'h0, r.sw_en};
        end
        `SPS_ADDR_STATUS: begin
          n.rdata = status;
        end
        `SPS_ADDR_STEPCNT: begin
          n.rdata = {16'h0, r.step_count};
        end
        default: begin
          n.rdata = 32'h0;
        end
      endcase
    end
    n.ready = 1'b1;
    n.resp = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.phase <= `SPS_PHASE_INIT;
      r.sw_en <= 1'(`SPS_CTRL_RESET);
      r.ready <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign hreadyout = r.ready;
  assign hresp = r.resp;
  assign hrdata = r.rdata;
  assign {winding1_pos, winding1_neg, winding2_pos, winding2_neg} = r.win;
  assign alarm_low_o = 1'b0;
  assign alarm_low_oe = r.alarm_oe;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence fwd_step_s;
    step && run && !dir_rev && exc_half;
  endsequence

  sequence rev_step_s;
    step && run && dir_rev && exc_half;
  endsequence

  sequence rst_pulse_s;
    !sys_run ##1 sys_run;
  endsequence

  rise_step_a: assert property (stp.rise_evt && edge_sel && run |=> r.phase != $past(r.phase))
    else $error("rising edge did not advance phase");
  fall_step_a: assert property (stp.fall_evt && !stp.rise_evt && edge_sel && sys_run
                                |=> r.phase == $past(r.phase))
    else $error("falling edge advanced phase in rising-only mode");
  half_fwd_a: assert property (fwd_step_s |=> r.phase == $past(r.phase) + 3'h1)
    else $error("half step forward wrong");
  half_rev_a: assert property (rev_step_s |=> r.phase == $past(r.phase) - 3'h1)
    else $error("half step reverse wrong");
  reset_hold_a: assert property (!sys_run |=> r.phase == `SPS_PHASE_INIT && !r.fault)
    else $error("sequencer not held in reset");
  reset_init_a: assert property (rst_pulse_s |-> r.phase == `SPS_PHASE_INIT ##1
                                 (r.win == 4'h9 || $past(!run || detect || step)))
    else $error("initial state not loaded");
  enable_off_a: assert property (!en_pin |=> r.win == 4'h0)
    else $error("outputs on while disabled");
  enable_hold_a: assert property (!en_pin && sys_run |=> $stable(r.phase))
    else $error("phase moved while disabled");
  alarm_drive_a: assert property (detect |=> alarm_low_oe [*2])
    else $error("alarm not driven on detection");
  fault_latch_a: assert property (r.fault && sys_run |=> r.fault && r.win == 4'h0)
    else $error("fault latch released without reset");
  full_even_a: assert property (step && run && !exc_half |=> !r.phase[0])
    else $error("full step left an odd position");

  // ****************************************
  // Stepping pattern checks
  // ****************************************
  sequence fwd_full_s;
    step && run && !dir_rev && !exc_half;
  endsequence

  sequence rev_full_s;
    step && run && dir_rev && !exc_half;
  endsequence

  both_edge_a: assert property (stp.fall_evt && !edge_sel && run |=> r.phase != $past(r.phase))
    else $error("falling edge did not advance phase");

  // Full-step moves two positions from an even phase
  full_fwd_a: assert property (fwd_full_s ##0 !r.phase[0] |=> r.phase == $past(r.phase) + 3'h2)
    else $error("full step forward wrong");

  full_rev_a: assert property (rev_full_s ##0 !r.phase[0] |=> r.phase == $past(r.phase) - 3'h2)
    else $error("full step reverse wrong");

  // From an odd phase the first full step re-aligns by one
  odd_fwd_a: assert property (fwd_full_s ##0 r.phase[0] |=> r.phase == $past(r.phase) + 3'h1)
    else $error("forward re-align wrong");

  odd_rev_a: assert property (rev_full_s ##0 r.phase[0] |=> r.phase == $past(r.phase) - 3'h1)
    else $error("reverse re-align wrong");

  // A mode change alone never moves the phase
  mode_keep_a: assert property ($changed(exc_half) && !step && sys_run |=> $stable(r.phase))
    else $error("excitation change moved phase");

  dir_keep_a: assert property ($changed(dir_rev) && !step && sys_run |=> $stable(r.phase))
    else $error("direction change moved phase");

  // ****************************************
  // Gating and latch checks
  // ****************************************
  win_on_a: assert property (run && !detect |=> r.win != 4'h0)
    else $error("windings off while running");

  gated_hold_a: assert property (step && !run && sys_run |=> $stable(r.phase))
    else $error("gated step moved phase");

  reset_off_a: assert property (!sys_run |=> r.win == 4'h0)
    else $error("windings on during reset");

  // Detection latches until the reset pin is pulsed
  fault_set_a: assert property (detect && sys_run |=> r.fault)
    else $error("detection not latched");

  alarm_quiet_a: assert property (!r.fault && !detect |=> !alarm_low_oe)
    else $error("alarm driven without detection");

  miss_set_a: assert property (step && !run |=> r.miss)
    else $error("gated step not flagged");

  // ****************************************
  // Register checks
  // ****************************************
  sequence count_write_s;
    r.wr_pend && r.wr_addr == `SPS_ADDR_STEPCNT;
  endsequence

  count_hold_a: assert property (!(step && run) && !r.wr_pend |=> $stable(r.step_count))
    else $error("step count moved without a step");

  count_clear_a: assert property (count_write_s |=> r.step_count == 16'h0)
    else $error("step count not cleared by write");

  // Read data stands for its data phase only
  read_idle_a: assert property (!(addr_ok && !hwrite) |=> hrdata == 32'h0)
    else $error("read data outside a read");

endmodule : sps_sequencer

// *** test/sps_ctl_model.sv ***
module sps_ctl_model (
  // Reference clock
  input wire logic hclk,
  // Controller pins
  output logic step_clock,
  output logic edge_select,
  output logic excitation_select,
  output logic direction_select,
  output logic enable,
  output logic system_reset_low
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    step_clock = 1'b0;
    {edge_select, excitation_select, direction_select} = 3'h4;
    enable = 1'b1;
    system_reset_low = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge hclk);
  endtask : hold

  // Mode levels settle 7 us before the next rising edge
  task automatic levels(input logic [2:0] m);
    @(posedge hclk);
    {edge_select, excitation_select, direction_select} <= m;
    hold(140);
  endtask : levels

  // Levels stay put for 7 us after each edge
  task automatic pulse();
    @(posedge hclk);
    step_clock <= 1'b1;
    hold(140);
    step_clock <= 1'b0;
    hold(140);
  endtask : pulse

  // A low-high reset pulse also clears a latched fault
  task automatic pins(input logic en, input logic rst);
    @(posedge hclk);
    enable <= en;
    system_reset_low <= rst;
    hold(20);
  endtask : pins
endmodule : sps_ctl_model

// *** test/stepper_phase_sequencer_test.sv ***
module stepper_phase_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic hclk = 1'b0;
  logic link_clk = 1'b0;
  logic hresetn = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] det = 2'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic step_clock, edge_select, excitation_select, direction_select, enable, system_reset_low;
  logic alarm_low_o;
  logic alarm_low_oe;
  wire [3:0] wind;
  // Open-drain alarm wire with pull-up
  wire alarm_w = alarm_low_oe ? alarm_low_o : 1'b1;
  int n_errors = 0;
  int comparisons = 0;
  int steps = 0;
  // Mode {edge, excitation, direction} beside the windings it should leave
  logic [6:0] rows [9] = '{{3'h4, 4'ha}, {3'h0, 4'h5}, {3'h6, 4'h1}, {3'h2, 4'h8}, {3'h5, 4'h9},
                           {3'h1, 4'h6}, {3'h7, 4'h2}, {3'h3, 4'h8}, {3'h0, 4'h6}};

  always #25 hclk = ~hclk;

  initial begin
    #3;
    forever #6 link_clk = ~link_clk;
  end

  sps_ctl_model ctl_u (.hclk(hclk), .step_clock(step_clock), .edge_select(edge_select),
    .excitation_select(excitation_select), .direction_select(direction_select), .enable(enable),
    .system_reset_low(system_reset_low));

  sps_sequencer dut_u (.hclk(hclk), .hresetn(hresetn), .link_clk(link_clk), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .step_clock(step_clock),
    .edge_select(edge_select), .excitation_select(excitation_select), .direction_select(direction_select),
    .enable(enable), .system_reset_low(system_reset_low), .overcurrent_detect(det[0]),
    .overheat_detect(det[1]), .winding1_pos(wind[3]), .winding1_neg(wind[2]), .winding2_pos(wind[1]),
    .winding2_neg(wind[0]), .alarm_low_i(alarm_w), .alarm_low_o(alarm_low_o), .alarm_low_oe(alarm_low_oe));

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    // Ready and read data are taken as they stood before the edge
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic test_done();
    if (n_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (40000) @(posedge hclk);
    n_errors++;
    test_done();
  end

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (10) @(posedge hclk);
    chk("windings", 32'h9, {28'h0, wind});
    bus(1'b0, 8'h00, 32'h0);
    chk("ctrl", 32'h1, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
    foreach (rows[i]) begin
      ctl_u.levels(rows[i][6:4]);
      ctl_u.pulse();
      steps += rows[i][6] ? 1 : 2;
      chk("windings", {28'h0, rows[i][3:0]}, {28'h0, wind});
    end
    bus(1'b0, 8'h08, 32'h0);
    chk("stepcnt", steps, rd);
    bus(1'b1, 8'h08, 32'h0);
    bus(1'b0, 8'h08, 32'h0);
    chk("stepcnt", 32'h0, rd);
    bus(1'b0, 8'h0c, 32'h0);
    chk("unmapped", 32'h0, rd);
    ctl_u.pins(1'b0, 1'b1);
    ctl_u.pulse();
    chk("windings", 32'h0, {28'h0, wind});
    ctl_u.pins(1'b1, 1'b1);
    chk("windings", 32'h6, {28'h0, wind});
    bus(1'b0, 8'h04, 32'h0);
    chk("missed", 32'h1, {31'h0, rd[10]});
    chk("phase", 32'h4, {29'h0, rd[2:0]});
    bus(1'b1, 8'h04, 32'h800);
    bus(1'b0, 8'h04, 32'h0);
    chk("missed", 32'h0, {31'h0, rd[10]});
    bus(1'b1, 8'h00, 32'h0);
    ctl_u.pulse();
    bus(1'b1, 8'h00, 32'h1);
    repeat (10) @(posedge hclk);
    chk("windings", 32'h6, {28'h0, wind});
    for (int i = 1; i < 3; i++) begin
      @(posedge hclk);
      det <= i[1:0];
      repeat (10) @(posedge hclk);
      chk("alarm", 32'h0, {31'h0, alarm_w});
      det <= 2'h0;
      repeat (10) @(posedge hclk);
      chk("windings", 32'h0, {28'h0, wind});
      ctl_u.pins(1'b1, 1'b0);
      ctl_u.pulse();
      chk("windings", 32'h0, {28'h0, wind});
      ctl_u.pins(1'b1, 1'b1);
      chk("windings", 32'h9, {28'h0, wind});
      chk("alarm", 32'h1, {31'h0, alarm_w});
    end
    // Mid-run reset restores the register and sequencer defaults
    bus(1'b1, 8'h00, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    chk("windings", 32'h0, {28'h0, wind});
    hresetn <= 1'b1;
    repeat (10) @(posedge hclk);
    chk("windings", 32'h9, {28'h0, wind});
    bus(1'b0, 8'h00, 32'h0);
    chk("ctrl", 32'h1, rd);
    test_done();
  end
endmodule : stepper_phase_sequencer_test
